// [include/slc_pkg.sv]
// shared constants and state type of the switch link control registers
package slc_pkg;

  localparam int NLINK  = 8;
  localparam int GAP_W  = 11;
  localparam int ADR_W  = 10;

  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_RSV_A = 8'h10;
  localparam logic [7:0] IDX_RSV_B = 8'h11;
  localparam logic [7:0] IDX_DBG   = 8'h1F;
  localparam logic [7:0] IDX_LSTAT = 8'h20;
  localparam logic [7:0] IDX_PSTAT = 8'h40;
  localparam logic [7:0] IDX_LCFG  = 8'h80;
  localparam logic [7:0] IDX_FWD   = 8'hA0;

  // debug origin fields
  localparam int DBG_RSV_BIT = 4;
  localparam int DBG_SRC_LSB = 0;

  // status fields
  localparam int DIR_LSB = 8;
  localparam int NET_LSB = 4;

  // link setup fields
  localparam int EN_BIT    = 31;
  localparam int WIDE_BIT  = 30;
  localparam int LINK_GREETING_TOKEN_BIT = 24;
  localparam int RXRST_BIT = 23;
  localparam int SGAP_LSB  = 11;
  localparam int TGAP_LSB  = 0;

  // fixed forwarding fields
  localparam int FWD_EN_BIT   = 31;
  localparam int FWD_CORE_BIT = 8;
  localparam int FWD_CHAN_LSB = 0;

  typedef struct packed {
    logic                        ack;
    logic [31:0]                 rdata;
    logic [1:0]                  rsv_a;
    logic [1:0]                  rsv_b;
    logic                        dbg_rsv;
    logic [1:0]                  dbg_src;
    logic [NLINK-1:0][3:0]       dir;
    logic [NLINK-1:0][1:0]       net;
    logic [NLINK-1:0][1:0]       pnet;
    logic [NLINK-1:0]            en;
    logic [NLINK-1:0]            wide;
    logic [NLINK-1:0]            err;
    logic [NLINK-1:0]            issued;
    logic [NLINK-1:0]            held;
    logic [NLINK-1:0]            rx_rst;
    logic [NLINK-1:0]            link_greeting_token;
    logic [NLINK-1:0][GAP_W-1:0] sgap;
    logic [NLINK-1:0][GAP_W-1:0] tgap;
    logic [NLINK-1:0]            fen;
    logic [NLINK-1:0]            fcore;
    logic [NLINK-1:0][4:0]       fchan;
    logic [3:0]                  route_dir;
    logic                        route_local;
  } slc_state_t;

  // every field comes out of reset at zero
  localparam slc_state_t STATE_RST = '0;

endpackage

// [include/slc_tx_if.sv]
// signals between the register block and one link transmit spacer
`timescale 1ns/1ps
interface slc_tx_if #(
  parameter int GAP_W = 11
);
  logic [GAP_W-1:0] sym_gap;
  logic [GAP_W-1:0] tok_gap;
  logic             allow;
  logic             valid;
  logic             last;
  logic             ready;

  modport spacer (
    input  sym_gap,
    input  tok_gap,
    input  allow,
    input  valid,
    input  last,
    output ready
  );

  modport ctrl (
    output sym_gap,
    output tok_gap,
    output allow,
    output valid,
    output last,
    input  ready
  );
endinterface

// [logic/slc_link_tx.sv]
// transmit spacer: idle clocks between symbols and between tokens
`timescale 1ns/1ps
module slc_link_tx #(
  parameter int GAP_W = 11
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  slc_tx_if.spacer  port
);

  initial begin
    if (GAP_W < 1 || GAP_W > 16) begin
      $error("slc_link_tx: GAP_W out of range");
    end
  end

  typedef struct packed {
    logic [GAP_W:0] cnt;
  } slc_tx_state_t;

  slc_tx_state_t q;
  slc_tx_state_t d;

  assign port.ready = port.allow && (q.cnt == '0);

  // ----------------------------------------------------------------
  // gap counter
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (port.valid && port.ready) begin
      // [R18] token spacing
      if (port.last) begin
        d.cnt = {1'b0, port.tok_gap} + (GAP_W+1)'(1);
      // [R17] symbol spacing
      end else begin
        d.cnt = {1'b0, port.sym_gap} + (GAP_W+1)'(1);
      end
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - (GAP_W+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_symbol_gap: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    port.valid && port.ready && !port.last |=> !port.ready)
    else $error("symbol sent without idle clock");
  a_token_gap: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    port.valid && port.ready && port.last && port.tok_gap == '0 |=> !port.ready ##1 (port.ready || !port.allow))
    else $error("token gap wrong");

endmodule

// [logic/slc_regs.sv]
// switch link control and status registers behind a classic wishbone slave
//
// How it works
// [R1] debug origin bit 1 marks second core, bit 0 first core, last event
// [R2] status bits 25:24 read link target type, read only
// [R3] status bits 23:16 read destination link while the link is in use
// [R4] external status bits 11:8 hold writable direction, reset zero
// [R5] bits 5:4 hold writable network number on both banks, reset zero
// [R6] status bit 2 reads one while current packet is junk
// [R7] status bit 1 reads one while destination side is busy
// [R8] status bit 0 reads one while source side is busy
// [R9] eight processor link status words, same fields, no direction
// [R10] setup bit 31 enables the link and steers shared pin muxing
// [R11] setup bit 30 picks two or five wires; both ends must match
// [R12] setup bit 27 flags receive overflow or illegal token, read only
// [R13] setup bit 26 shows credit issued to the remote end
// [R14] setup bit 25 shows credit held; transmit only while held
// [R15] command bit 24 drops held credit and sends a greeting token
// [R16] write-only bit 23 resets the receiver to token start
// [R17] at least field plus one idle clocks between symbols
// [R18] at least field plus one idle clocks between tokens
// [R19] forwarding bit 31 sends all traffic to a fixed endpoint
// [R20] forwarding bit 8 picks the destination processor
// [R21] forwarding bits 4:0 pick the destination channel endpoint
// [R22] forwarding words map in order to links C D A B G H E F
// [R23] route by most significant mismatching node identifier bit
// [R24] reserved and read-only bits ignore writes beyond storage
// [R25] error flag stays set until receiver reset or greeting
`timescale 1ns/1ps
module slc_regs #(
  parameter int GAP_W = slc_pkg::GAP_W
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [slc_pkg::ADR_W-1:0]           wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  input  wire logic                                first_core_debug_i,
  input  wire logic                                second_core_debug_i,
  input  wire logic [slc_pkg::NLINK-1:0][1:0]      link_target_type_i,
  input  wire logic [slc_pkg::NLINK-1:0][7:0]      link_dest_i,
  input  wire logic [slc_pkg::NLINK-1:0]           link_junk_i,
  input  wire logic [slc_pkg::NLINK-1:0]           link_dst_busy_i,
  input  wire logic [slc_pkg::NLINK-1:0]           link_src_busy_i,
  input  wire logic [slc_pkg::NLINK-1:0][1:0]      processor_link_target_type_i,
  input  wire logic [slc_pkg::NLINK-1:0][7:0]      processor_link_dest_i,
  input  wire logic [slc_pkg::NLINK-1:0]           processor_link_junk_i,
  input  wire logic [slc_pkg::NLINK-1:0]           processor_link_dst_busy_i,
  input  wire logic [slc_pkg::NLINK-1:0]           processor_link_src_busy_i,
  input  wire logic [slc_pkg::NLINK-1:0]           rx_overflow_i,
  input  wire logic [slc_pkg::NLINK-1:0]           rx_bad_token_i,
  input  wire logic [slc_pkg::NLINK-1:0]           credit_issue_i,
  input  wire logic [slc_pkg::NLINK-1:0]           credit_grant_i,
  input  wire logic [slc_pkg::NLINK-1:0]           tx_valid_i,
  input  wire logic [slc_pkg::NLINK-1:0]           tx_last_i,
  output logic      [slc_pkg::NLINK-1:0]           tx_ready_o,
  output logic      [slc_pkg::NLINK-1:0]           link_enable_o,
  output logic      [slc_pkg::NLINK-1:0]           link_wide_o,
  output logic      [slc_pkg::NLINK-1:0]           rx_reset_o,
  output logic      [slc_pkg::NLINK-1:0]           greeting_o,
  output logic      [slc_pkg::NLINK-1:0]           fwd_enable_o,
  output logic      [slc_pkg::NLINK-1:0]           fwd_core_o,
  output logic      [slc_pkg::NLINK-1:0][4:0]      fwd_chan_o,
  input  wire logic [15:0]                         node_id_i,
  input  wire logic [15:0]                         route_node_i,
  input  wire logic [15:0][3:0]                    route_table_i,
  output logic      [3:0]                          route_dir_o,
  output logic                                     route_local_o
);

  localparam int N = slc_pkg::NLINK;

  initial begin
    if (GAP_W != slc_pkg::GAP_W) begin
      $error("slc_regs: GAP_W must match the setup field width");
    end
  end

  slc_pkg::slc_state_t q;
  slc_pkg::slc_state_t d;
  logic [7:0]          idx;
  logic [2:0]          k;
  logic [31:0]         rword;
  logic                wr;

  assign idx = wb_adr_i[slc_pkg::ADR_W-1:2];
  assign k   = idx[2:0];
  assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a >= base) && (a < base + 8'(N));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old & ~m) | (dat & m);
  endfunction

  function automatic logic [31:0] stat_word(input logic [1:0] tt, input logic [7:0] dest,
                                            input logic [3:0] dir, input logic [1:0] net,
                                            input logic junk, input logic db, input logic sb);
    logic [7:0] shown;
    shown = (db || sb) ? dest : 8'h00;
    stat_word = {6'h00, tt, shown, 4'h0, dir, 2'h0, net, 1'b0, junk, db, sb};
  endfunction

  // [R23] highest mismatching bit wins
  function automatic logic [3:0] route_pick(input logic [15:0] own, input logic [15:0] dst,
                                            input logic [15:0][3:0] tbl);
    logic [15:0] diff;
    diff = own ^ dst;
    route_pick = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        route_pick = tbl[i];
      end
    end
  endfunction

  // [R22] link letter of a forwarding word
  function automatic logic [2:0] fwd_link(input logic [2:0] word);
    fwd_link = word ^ 3'h2;
  endfunction

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rword = 32'h0000_0000;
    if (idx == slc_pkg::IDX_RSV_A) begin
      rword = {30'h0, q.rsv_a};
    end else if (idx == slc_pkg::IDX_RSV_B) begin
      rword = {30'h0, q.rsv_b};
    end else if (idx == slc_pkg::IDX_DBG) begin
      // [R1] origin of last debug event
      rword = {27'h0, q.dbg_rsv, 2'h0, q.dbg_src};
    end else if (in_bank(idx, slc_pkg::IDX_LSTAT)) begin
      // [R2] [R3] [R6] [R7] [R8] live link state
      rword = stat_word(link_target_type_i[k], link_dest_i[k], q.dir[k], q.net[k],
                        link_junk_i[k], link_dst_busy_i[k], link_src_busy_i[k]);
    end else if (in_bank(idx, slc_pkg::IDX_PSTAT)) begin
      // [R9] processor bank, direction reads zero
      rword = stat_word(processor_link_target_type_i[k], processor_link_dest_i[k], 4'h0,
                        q.pnet[k], processor_link_junk_i[k], processor_link_dst_busy_i[k],
                        processor_link_src_busy_i[k]);
    end else if (in_bank(idx, slc_pkg::IDX_LCFG)) begin
      // [R12] [R13] [R14] flags; command bits read zero
      rword = {q.en[k], q.wide[k], 2'h0, q.err[k], q.issued[k], q.held[k], 3'h0,
               q.sgap[k], q.tgap[k]};
    end else if (in_bank(idx, slc_pkg::IDX_FWD)) begin
      rword = {q.fen[k], 22'h0, q.fcore[k], 3'h0, q.fchan[k]};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    w = merge(rword, wb_dat_i, wb_sel_i);
    d = q;
    d.ack    = wb_cyc_i && wb_stb_i && !q.ack;
    d.rx_rst = '0;
    d.link_greeting_token  = '0;
    if (d.ack) begin
      d.rdata = rword;
    end
    // writes land on the edge that sees ack high
    // [R24] only writable fields are stored
    if (wr) begin
      if (idx == slc_pkg::IDX_RSV_A) begin
        d.rsv_a = w[1:0];
      end else if (idx == slc_pkg::IDX_RSV_B) begin
        d.rsv_b = w[1:0];
      end else if (idx == slc_pkg::IDX_DBG) begin
        d.dbg_rsv = w[slc_pkg::DBG_RSV_BIT];
        d.dbg_src = w[slc_pkg::DBG_SRC_LSB +: 2];
      end else if (in_bank(idx, slc_pkg::IDX_LSTAT)) begin
        // [R4] [R5] direction and network
        d.dir[k] = w[slc_pkg::DIR_LSB +: 4];
        d.net[k] = w[slc_pkg::NET_LSB +: 2];
      end else if (in_bank(idx, slc_pkg::IDX_PSTAT)) begin
        // [R5] processor link network
        d.pnet[k] = w[slc_pkg::NET_LSB +: 2];
      end else if (in_bank(idx, slc_pkg::IDX_LCFG)) begin
        // [R10] [R11] enable and width
        d.en[k]   = w[slc_pkg::EN_BIT];
        d.wide[k] = w[slc_pkg::WIDE_BIT];
        d.sgap[k] = w[slc_pkg::SGAP_LSB +: GAP_W];
        d.tgap[k] = w[slc_pkg::TGAP_LSB +: GAP_W];
        // [R15] greeting drops held credit
        if (wb_sel_i[3] && wb_dat_i[slc_pkg::LINK_GREETING_TOKEN_BIT]) begin
          d.link_greeting_token[k]  = 1'b1;
          d.held[k]   = 1'b0;
          d.issued[k] = 1'b0;
          d.err[k]    = 1'b0;
        end
        // [R16] receiver reset pulse
        if (wb_sel_i[2] && wb_dat_i[slc_pkg::RXRST_BIT]) begin
          d.rx_rst[k] = 1'b1;
          d.err[k]    = 1'b0;
        end
      end else if (in_bank(idx, slc_pkg::IDX_FWD)) begin
        // [R19] [R20] [R21] fixed forwarding
        d.fen[k]   = w[slc_pkg::FWD_EN_BIT];
        d.fcore[k] = w[slc_pkg::FWD_CORE_BIT];
        d.fchan[k] = w[slc_pkg::FWD_CHAN_LSB +: 5];
      end
    end
    // hardware events win over clears
    for (int i = 0; i < N; i++) begin
      // [R12] [R25] sticky error
      if (rx_overflow_i[i] || rx_bad_token_i[i]) begin
        d.err[i] = 1'b1;
      end
      // [R13] credit issued
      if (credit_issue_i[i]) begin
        d.issued[i] = 1'b1;
      end
      // [R14] credit received
      if (credit_grant_i[i]) begin
        d.held[i] = 1'b1;
      end
    end
    // [R1] last event source
    if (first_core_debug_i || second_core_debug_i) begin
      d.dbg_src = {second_core_debug_i, first_core_debug_i};
    end
    // [R23] routing decision
    d.route_dir   = route_pick(node_id_i, route_node_i, route_table_i);
    d.route_local = (node_id_i == route_node_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= slc_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o      = q.ack;
  assign wb_dat_o      = q.rdata;
  assign link_enable_o = q.en;
  assign link_wide_o   = q.wide;
  assign rx_reset_o    = q.rx_rst;
  assign greeting_o    = q.link_greeting_token;
  assign route_dir_o   = q.route_dir;
  assign route_local_o = q.route_local;

  // [R22] word order C D A B G H E F
  always_comb begin
    fwd_enable_o = '0;
    fwd_core_o   = '0;
    fwd_chan_o   = '0;
    for (int i = 0; i < N; i++) begin
      fwd_enable_o[fwd_link(3'(i))] = q.fen[i];
      fwd_core_o[fwd_link(3'(i))]   = q.fcore[i];
      fwd_chan_o[fwd_link(3'(i))]   = q.fchan[i];
    end
  end

  // ----------------------------------------------------------------
  // transmit spacers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_tx
    slc_tx_if #(.GAP_W(GAP_W)) tx ();
    assign tx.sym_gap = q.sgap[g];
    assign tx.tok_gap = q.tgap[g];
    // [R14] send only with credit
    assign tx.allow   = q.en[g] && q.held[g];
    assign tx.valid   = tx_valid_i[g];
    assign tx.last    = tx_last_i[g];
    assign tx_ready_o[g] = tx.ready;
    slc_link_tx #(.GAP_W(GAP_W)) u_tx (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .port  (tx)
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) // [R24]
    else $error("ack held more than one cycle");
  a_debug_second: assert property (second_core_debug_i && !first_core_debug_i |=> q.dbg_src == 2'b10) // [R1]
    else $error("second core not recorded");
  a_greet_clear: assert property (wr && idx == slc_pkg::IDX_LCFG && wb_sel_i[3] && // [R15]
    wb_dat_i[slc_pkg::LINK_GREETING_TOKEN_BIT] && !credit_grant_i[0] |=> !q.held[0] && greeting_o[0])
    else $error("greeting did not clear credit");
  a_err_sticky: assert property (q.err[0] && !rx_reset_o[0] && !greeting_o[0] && // [R25]
    !(wr && idx == slc_pkg::IDX_LCFG) |=> q.err[0])
    else $error("error flag lost");
  a_err_set: assert property (rx_overflow_i[3] || rx_bad_token_i[3] |=> q.err[3]) // [R12]
    else $error("error flag not set");
  a_may_send: assert property (tx_ready_o[1] |-> link_enable_o[1] && q.held[1]) // [R14]
    else $error("transmit without credit");
  a_static_order: assert property (q.fen[0] |-> fwd_enable_o[2]) // [R22]
    else $error("forwarding word order wrong");
  a_src_busy_read: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !q.ack && // [R8]
    idx == slc_pkg::IDX_LSTAT |=> wb_ack_o && wb_dat_o[0] == $past(link_src_busy_i[0]))
    else $error("source busy read wrong");
  a_rx_reset_pulse: assert property (wr && idx == slc_pkg::IDX_LCFG && wb_sel_i[2] && // [R16]
    wb_dat_i[slc_pkg::RXRST_BIT] |=> rx_reset_o[0] ##1 !rx_reset_o[0])
    else $error("receiver reset not a pulse");
  a_enable_store: assert property (wr && idx == slc_pkg::IDX_LCFG && wb_sel_i[3] |=> // [R10]
    link_enable_o[0] == $past(wb_dat_i[slc_pkg::EN_BIT])) else $error("enable not stored");
  a_width_store: assert property (wr && idx == slc_pkg::IDX_LCFG && wb_sel_i[3] |=> // [R11]
    link_wide_o[0] == $past(wb_dat_i[slc_pkg::WIDE_BIT])) else $error("width not stored");
  a_dir_store: assert property (wr && idx == slc_pkg::IDX_LSTAT + 8'h03 && wb_sel_i[1] |=> // [R4]
    q.dir[3] == $past(wb_dat_i[slc_pkg::DIR_LSB +: 4])) else $error("direction not stored");
  a_pnet_store: assert property (wr && idx == slc_pkg::IDX_PSTAT + 8'h01 && wb_sel_i[0] |=> // [R5]
    q.pnet[1] == $past(wb_dat_i[slc_pkg::NET_LSB +: 2])) else $error("network not stored");
  a_fwd_store: assert property (wr && idx == slc_pkg::IDX_FWD && wb_sel_i[3] |=> // [R19]
    fwd_enable_o[2] == $past(wb_dat_i[slc_pkg::FWD_EN_BIT])) else $error("forwarding not stored");
  a_issue_set: assert property (credit_issue_i[0] |=> q.issued[0]) // [R13]
    else $error("issued flag not set");
  a_grant_set: assert property (credit_grant_i[0] |=> q.held[0]) // [R14]
    else $error("held flag not set");
  a_debug_first: assert property (first_core_debug_i && !second_core_debug_i |=> q.dbg_src == 2'b01) // [R1]
    else $error("first core not recorded");
  a_route_local: assert property (node_id_i == route_node_i |=> route_local_o && route_dir_o == 4'h0) // [R23]
    else $error("local route wrong");

  c_write: cover property (wr && in_bank(idx, slc_pkg::IDX_LCFG));
  c_greet_grant: cover property (greeting_o[0] ##[1:20] q.held[0]);
  c_tx_token: cover property (tx_valid_i[0] && tx_ready_o[0] && tx_last_i[0]);

endmodule

// [bench/slc_remote_link.sv]
// remote link endpoint model for link 0: credit answer and symbol source
`timescale 1ns/1ps
module slc_remote_link (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic greeting_i,
  input  wire logic ready_i,
  input  wire logic send_i,
  output logic      grant_o,
  output logic      valid_o,
  output logic      last_o
);
  logic [2:0] wait_q;
  logic       held_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      grant_o <= 1'b0;
      wait_q  <= 3'h0;
      held_q  <= 1'b0;
      valid_o <= 1'b0;
      last_o  <= 1'b0;
    end else begin
      grant_o <= !greeting_i && wait_q == 3'h1;
      // greeting answered by a credit grant
      if (greeting_i) begin
        wait_q <= 3'h3;
        held_q <= 1'b0;
      end else if (wait_q == 3'h1) begin
        held_q  <= 1'b1;
        wait_q  <= 3'h0;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
      // offers only while credit held, same width assumed
      if (valid_o && ready_i) begin
        last_o <= !last_o;
      end
      valid_o <= send_i && held_q;
    end
  end
endmodule

// [bench/tb_slc_regs.sv]
// register and spacing test of the switch link control block
`timescale 1ns/1ps
module tb_slc_regs;
  localparam int SGAP = 2;
  localparam int TGAP = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [9:0] wb_adr = 10'h000;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, dbg0 = 1'b0, dbg1 = 1'b0, send = 1'b0, grant, txv, txl, rx_seen = 1'b0, gr_seen = 1'b0;
  logic [7:0][1:0] ltype = 16'h0080, ptype = 16'h0004;
  logic [7:0][7:0] ldest = 64'h5A000000, pdest = 64'h3300;
  logic [7:0] ljunk = 8'h08, ldst = 8'h08, lsrc = 8'h00, pjunk = 8'h00, pdst = 8'h00, psrc = 8'h02;
  logic [7:0] ovf = 8'h00, bad = 8'h00, issue = 8'h00;
  logic [7:0] tx_ready_o, link_enable_o, link_wide_o, rx_reset_o, greeting_o, fwd_enable_o, fwd_core_o;
  logic [7:0][4:0] fwd_chan_o;
  logic [15:0] node_id = 16'h0005, route_node = 16'h0085;
  logic [15:0][3:0] route_table = 64'hFEDCBA9876543210;
  logic [3:0] route_dir_o;
  logic route_local_o;
  int fail_count = 0, samples_checked = 0, cyc_n = 0, n_take = 0;
  int t_cyc [6];
  logic t_last [6];
  int lt [8] = '{2, 3, 0, 1, 6, 7, 4, 5};

  slc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_core_debug_i(dbg0), .second_core_debug_i(dbg1), .link_target_type_i(ltype),
    .link_dest_i(ldest), .link_junk_i(ljunk), .link_dst_busy_i(ldst), .link_src_busy_i(lsrc),
    .processor_link_target_type_i(ptype), .processor_link_dest_i(pdest), .processor_link_junk_i(pjunk),
    .processor_link_dst_busy_i(pdst), .processor_link_src_busy_i(psrc), .rx_overflow_i(ovf),
    .rx_bad_token_i(bad), .credit_issue_i(issue), .credit_grant_i({7'h00, grant}),
    .tx_valid_i({7'h00, txv}), .tx_last_i({7'h00, txl}), .tx_ready_o(tx_ready_o),
    .link_enable_o(link_enable_o), .link_wide_o(link_wide_o), .rx_reset_o(rx_reset_o),
    .greeting_o(greeting_o), .fwd_enable_o(fwd_enable_o), .fwd_core_o(fwd_core_o), .fwd_chan_o(fwd_chan_o),
    .node_id_i(node_id), .route_node_i(route_node), .route_table_i(route_table),
    .route_dir_o(route_dir_o), .route_local_o(route_local_o));

  slc_remote_link remote (.clk_i(clk_i), .rst_i(rst_i), .greeting_i(greeting_o[0]),
    .ready_i(tx_ready_o[0]), .send_i(send), .grant_o(grant), .valid_o(txv), .last_o(txl));

  always #10 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks and monitor
  // ----------------------------------------
  task report_and_stop();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb_xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= {idx, 2'b00};
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) fail_count++;
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    wb_xfer(1'b1, idx, d, rd);
    @(posedge clk_i);
  endtask

  task rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    wb_xfer(1'b0, idx, 32'h0, rd);
    check(nm, rd, exp);
  endtask

  always @(posedge clk_i) begin
    cyc_n++;
    if (rx_reset_o[0] === 1'b1) rx_seen = 1'b1;
    if (greeting_o[0] === 1'b1) gr_seen = 1'b1;
    if (txv && tx_ready_o[0] === 1'b1 && n_take < 6) begin
      t_cyc[n_take] = cyc_n;
      t_last[n_take] = txl;
      n_take++;
    end
    if (cyc_n == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h80, 32'h0, "setup reset");
    rd_chk(8'h20, 32'h0, "status reset");
    wr(8'h23, 32'hFFFFFFFF);
    rd_chk(8'h23, 32'h025A0F36, "link status");
    ldst <= 8'h00;
    rd_chk(8'h23, 32'h02000F34, "link idle");
    wr(8'h41, 32'hFFFFFFFF);
    rd_chk(8'h41, 32'h01330031, "proc status");
    dbg1 <= 1'b1;
    @(posedge clk_i) dbg1 <= 1'b0;
    rd_chk(8'h1F, 32'h2, "debug second");
    dbg0 <= 1'b1;
    @(posedge clk_i) dbg0 <= 1'b0;
    rd_chk(8'h1F, 32'h1, "debug first");
    wr(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h3, "reserved word");
    wr(8'h28, 32'hFFFFFFFF);
    rd_chk(8'h28, 32'h0, "unmapped");
    wr(8'h80, 32'hC0001004);
    check("enable", {24'h0, link_enable_o}, 32'h1);
    check("wide", {24'h0, link_wide_o}, 32'h1);
    ovf <= 8'h01;
    @(posedge clk_i) ovf <= 8'h00;
    rd_chk(8'h80, 32'hC8001004, "overflow err");
    wr(8'h80, 32'hC0801004);
    rd_chk(8'h80, 32'hC0001004, "err cleared");
    check("rx reset", {31'h0, rx_seen}, 32'h1);
    bad <= 8'h01;
    @(posedge clk_i) bad <= 8'h00;
    issue <= 8'h01;
    @(posedge clk_i) issue <= 8'h00;
    rd_chk(8'h80, 32'hCC001004, "token err issued");
    check("ready no credit", {31'h0, tx_ready_o[0]}, 32'h0);
    wr(8'h80, 32'hC1001004);
    repeat (8) @(posedge clk_i);
    check("greeting", {31'h0, gr_seen}, 32'h1);
    rd_chk(8'h80, 32'hC2001004, "credit held");
    send <= 1'b1;
    for (int i = 0; i < 300 && n_take < 6; i++) @(posedge clk_i);
    for (int i = 1; i < 6; i++) check("spacing", t_cyc[i] - t_cyc[i-1], t_last[i-1] ? TGAP + 2 : SGAP + 2);
    wr(8'h80, 32'h00001004);
    check("disabled", {16'h0, link_enable_o, tx_ready_o}, 32'h0);
    for (int k = 0; k < 8; k++) wr(8'hA0 + k[7:0], 32'h80000000 | {k[0], 8'h00} | (k + 8));
    for (int k = 0; k < 8; k++) check("fwd", {fwd_core_o[lt[k]], fwd_chan_o[lt[k]]}, {k[0], 5'(k + 8)});
    check("fwd en", {24'h0, fwd_enable_o}, 32'hFF);
    wr(8'hA0, 32'hFFFFFFFF);
    rd_chk(8'hA0, 32'h8000011F, "fwd reserved");
    check("route 7", {route_local_o, route_dir_o}, 5'h07);
    route_node <= 16'h8005;
    repeat (3) @(posedge clk_i);
    check("route 15", {route_local_o, route_dir_o}, 5'h0F);
    route_node <= 16'h0005;
    repeat (3) @(posedge clk_i);
    check("route local", {route_local_o, route_dir_o}, 5'h10);
    report_and_stop();
  end
endmodule
